/* File: design/fspc_ctrl.sv */
// Flash self-programming controller: control register, command windows, page buffer,
// region-busy tracking, CPU halt, lock bits and fuse/lock readback over APB.
// Assumes APB master on pclk; store/load instructions arrive as APB accesses.
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
module fspc_ctrl
    import fspc_pkg::*;
#(
    parameter int PAGE_WORDS = PAGE_WORDS_DEF,
    parameter int HALT_FIRST_PAGE = HALT_FIRST_PAGE_DEF,
    parameter int OP_CYCLES = OP_CYCLES_DEF,
    parameter logic [15:0] BOOT_RESET_ADDR = BOOT_RESET_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic boot_vector_fuse,
    input wire logic [7:0] fuse_low,
    input wire logic [7:0] fuse_high,
    input wire logic global_irq_flag,
    input wire logic eeprom_busy,
    input wire logic [$clog2(PAGE_WORDS)-1:0] flash_buf_idx,
    output logic [15:0] flash_buf_data,
    output fspc_flash_cmd_t flash_cmd,
    output logic flash_busy,
    output logic cpu_halt,
    output logic region_read_block,
    output logic store_ready_irq,
    output logic [15:0] reset_vector
);
    localparam int WIDX = $clog2(PAGE_WORDS);
    localparam logic [15:0] HALT_PG = 16'(HALT_FIRST_PAGE);
    localparam logic [15:0] OP_LEN = 16'(OP_CYCLES);

    if (PAGE_WORDS < 2 || (PAGE_WORDS & (PAGE_WORDS - 1)) != 0 || WIDX > 14) begin : g_bad_page
        $error("PAGE_WORDS must be a power of two from 2 to 16384");
    end
    if (OP_CYCLES < 4 || OP_CYCLES > 65535) begin : g_bad_op
        $error("OP_CYCLES must lie between 4 and 65535");
    end

    logic pready_q;
    logic [31:0] prdata_q;
    logic ie_q;
    logic busy_q;
    logic [4:0] cmd_q;
    logic [2:0] win_q;
    logic [2:0] lpm_q;
    logic [15:0] z_q;
    logic [15:0] data_q;
    logic [7:0] lock_q;
    logic op_active_q;
    logic op_readable_q;
    logic op_write_q;
    logic [15:0] op_page_q;
    logic [15:0] op_cnt_q;
    fspc_flash_cmd_t flash_cmd_q;
    logic [15:0] vector_q;
    logic vector_taken_q;
    logic [15:0] busy_run_q;

    // APB: one wait state so read data always comes from a register
    logic access;
    logic done;
    logic ctrl_wr;
    logic cmd_ok;
    logic store_ok;
    logic lpm_ok;
    logic lpm_rd;
    logic op_start;
    logic op_end;
    logic buf_wr;
    logic buf_clear;
    logic [15:0] z_page;
    logic [7:0] lpm_byte;
    logic [31:0] rd_d;

    assign access = psel & penable;
    assign done = access & pready_q;
    assign pready = pready_q;
    assign pslverr = pready_q & ~fspc_addr_known(paddr);
    assign prdata = prdata_q;

    assign z_page = {{(WIDX + 1){1'b0}}, z_q[15:WIDX+1]};
    // Busy controller ignores new commands; EEPROM writes lock out commands, stores and lock/fuse reads
    assign ctrl_wr = done & pwrite & (paddr == CTRL_OFS);
    assign cmd_ok = ctrl_wr & ~op_active_q & ~eeprom_busy
                    & fspc_cmd_legal(pwdata[4:0]);
    assign store_ok = done & pwrite & (paddr == STORE_OFS) & cmd_q[STORE_EN_BIT]
                      & (win_q != 3'h0) & ~op_active_q & ~eeprom_busy;
    assign lpm_ok = (cmd_q == CMD_LOCK) & (lpm_q != 3'h0) & ~eeprom_busy;
    assign lpm_rd = done & ~pwrite & (paddr == LOAD_OFS) & lpm_ok;
    assign op_start = store_ok & ((cmd_q == CMD_ERASE) | (cmd_q == CMD_WRITE));
    assign op_end = op_active_q & (op_cnt_q == 16'h0001);
    assign buf_wr = store_ok & (cmd_q == CMD_LOAD);
    assign buf_clear = (op_end & op_write_q)
                       | (cmd_ok & (pwdata[4:0] == CMD_REEN));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= access & ~pready_q;
        end
    end

    // Without a flash array attached, plain loads return erased bytes
    always_comb begin
        lpm_byte = ERASED_BYTE;
        if (lpm_ok) begin
            // Pointer 1 reads lock bits, 0 the low fuses, 3 the high fuses
            lpm_byte = z_q[0] ? (z_q[1] ? fuse_high : lock_q) : fuse_low;
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        case (paddr)
            CTRL_OFS: rd_d = {24'h000000, ie_q, busy_q, 1'b0, cmd_q};
            PTR_OFS: rd_d = {16'h0000, z_q};
            DATA_OFS: rd_d = {16'h0000, data_q};
            LOAD_OFS: rd_d = {24'h000000, lpm_byte};
            STATUS_OFS: rd_d = {22'h000000, op_active_q, eeprom_busy, lock_q};
            default: rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (access & ~pready_q & ~pwrite) begin
            prdata_q <= rd_d;
        end
    end

    // Pointer and data word for store instructions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            z_q <= 16'h0000;
            data_q <= 16'h0000;
        end else if (done & pwrite) begin
            if (paddr == PTR_OFS) begin
                z_q <= pwdata[15:0];
            end
            if (paddr == DATA_OFS) begin
                data_q <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ie_q <= CTRL_RESET[IE_BIT];
        end else if (ctrl_wr) begin
            ie_q <= pwdata[IE_BIT];
        end
    end

    // Command bits and their windows; counting starts on the edge after the write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q <= CMD_IDLE;
            win_q <= 3'h0;
            lpm_q <= 3'h0;
        end else if (cmd_ok) begin
            cmd_q <= pwdata[4:0];
            win_q <= STORE_WINDOW;
            lpm_q <= LPM_WINDOW;
        end else if (op_start) begin
            win_q <= 3'h0;
            lpm_q <= 3'h0;
        end else if (op_end | (store_ok & ~op_start) | lpm_rd) begin
            cmd_q <= CMD_IDLE;
            win_q <= 3'h0;
            lpm_q <= 3'h0;
        end else if (~op_active_q) begin
            if (win_q != 3'h0) begin
                win_q <= win_q - 3'h1;
            end
            if (lpm_q != 3'h0) begin
                lpm_q <= lpm_q - 3'h1;
            end
            if (win_q == 3'h1) begin
                cmd_q <= CMD_IDLE;
            end
        end
    end

    // Busy flag: only set by an op start, only cleared by stores, so they never collide
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= CTRL_RESET[BUSY_BIT];
        end else if (op_start & (z_page < HALT_PG)) begin
            busy_q <= 1'b1;
        end else if (store_ok & ((cmd_q == CMD_LOAD) | (cmd_q == CMD_REEN))) begin
            busy_q <= 1'b0;
        end
    end

    // Operation tracker; address captured once so the pointer is free afterwards
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_active_q <= 1'b0;
            op_readable_q <= 1'b0;
            op_write_q <= 1'b0;
            op_page_q <= 16'h0000;
            op_cnt_q <= 16'h0000;
        end else if (op_start) begin
            op_active_q <= 1'b1;
            op_readable_q <= z_page < HALT_PG;
            op_write_q <= cmd_q == CMD_WRITE;
            op_page_q <= z_page;
            op_cnt_q <= OP_LEN;
        end else if (op_active_q) begin
            op_cnt_q <= op_cnt_q - 16'h0001;
            if (op_end) begin
                op_active_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_cmd_q <= '0;
        end else begin
            flash_cmd_q.erase <= op_start & (cmd_q == CMD_ERASE);
            flash_cmd_q.write <= op_start & (cmd_q == CMD_WRITE);
            flash_cmd_q.page <= op_start ? z_page : op_page_q;
        end
    end

    // Lock bits can only be programmed, never erased, from software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_q <= LOCK_RESET;
        end else if (store_ok & (cmd_q == CMD_LOCK)) begin
            lock_q <= lock_q & (data_q[7:0] | LOCK_KEEP);
        end
    end

    // Boot fuse sampled by a clocked process after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_q <= APP_RESET_ADDR;
            vector_taken_q <= 1'b0;
        end else if (!vector_taken_q) begin
            vector_q <= boot_vector_fuse ? APP_RESET_ADDR : BOOT_RESET_ADDR;
            vector_taken_q <= 1'b1;
        end
    end

    fspc_page_buf #(
        .WORDS(PAGE_WORDS),
        .DW(16)
    ) u_buf (
        .clk(pclk),
        .rst_n(presetn),
        .clear(buf_clear),
        .wr_en(buf_wr),
        .wr_idx(z_q[WIDX:1]),
        .wr_data(data_q),
        .rd_idx(flash_buf_idx),
        .rd_data(flash_buf_data)
    );

    assign flash_cmd = flash_cmd_q;
    assign flash_busy = op_active_q;
    assign cpu_halt = op_active_q & ~op_readable_q;
    assign region_read_block = busy_q;
    assign store_ready_irq = ie_q & global_irq_flag & ~cmd_q[STORE_EN_BIT];
    assign reset_vector = vector_q;

    // Own count of busy cycles, so the length check does not lean on op_cnt_q
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_run_q <= 16'h0000;
        end else if (op_active_q) begin
            busy_run_q <= busy_run_q + 16'h0001;
        end else begin
            busy_run_q <= 16'h0000;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_vector_hold: assert property (vector_taken_q |=> $stable(reset_vector))
        else $error("reset vector changed after capture");
    a_ready_irq: assert property ((ie_q && global_irq_flag && !cmd_q[STORE_EN_BIT])
        |-> store_ready_irq)
        else $error("ready interrupt not requested");
    a_busy_set: assert property ((op_start && z_page < HALT_PG) |=> busy_q [*4])
        else $error("busy flag not held after region op start");
    a_lock_program: assert property ((lock_q & ~$past(lock_q)) == 8'h00)
        else $error("lock bit returned to unprogrammed");
    a_store_window: assert property ((cmd_ok ##1 !cmd_ok [*4])
        |=> (cmd_q == CMD_IDLE || op_active_q))
        else $error("store window outlived four cycles");
    a_halt_region: assert property ((op_start && !(z_page < HALT_PG))
        |=> cpu_halt [*4])
        else $error("cpu not halted for halting region op");
    a_store_en_hold: assert property (op_active_q |-> cmd_q[STORE_EN_BIT])
        else $error("store enable dropped during operation");
    a_cmd_legal: assert property (cmd_q == CMD_IDLE || fspc_cmd_legal(cmd_q))
        else $error("illegal command pattern latched");
    a_reserved_zero: assert property ((done && !pwrite && paddr == CTRL_OFS)
        |-> !prdata[5])
        else $error("reserved control bit read as one");
    a_page_latched: assert property ((op_active_q && $past(op_active_q))
        |-> $stable(op_page_q))
        else $error("latched page changed during operation");
    a_eeprom_block: assert property (eeprom_busy |-> !op_start && !buf_wr && !lpm_rd)
        else $error("self-programming during eeprom write");
    a_op_length: assert property ($fell(flash_busy) |-> busy_run_q == OP_LEN)
        else $error("operation length wrong");

    c_erase_readable: cover property (op_start && z_page < HALT_PG && cmd_q == CMD_ERASE);
    c_page_load: cover property (buf_wr);
    c_lock_read: cover property (lpm_rd && z_q[0]);
    c_reenable: cover property (store_ok && cmd_q == CMD_REEN && busy_q);
    c_lock_program: cover property (store_ok && cmd_q == CMD_LOCK);
endmodule : fspc_ctrl

/* File: design/fspc_pkg.sv */
// Shared constants, types and decode helpers for the flash self-programming controller.
// Assumes a single pclk domain and an APB master with 8-bit byte addresses.
package fspc_pkg;
    // APB register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] PTR_OFS = 8'h04;
    localparam logic [7:0] DATA_OFS = 8'h08;
    localparam logic [7:0] STORE_OFS = 8'h0c;
    localparam logic [7:0] LOAD_OFS = 8'h10;
    localparam logic [7:0] STATUS_OFS = 8'h14;
    // Control register fields
    localparam int IE_BIT = 7;
    localparam int BUSY_BIT = 6;
    localparam int STORE_EN_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Low five-bit command patterns
    localparam logic [4:0] CMD_IDLE = 5'h00;
    localparam logic [4:0] CMD_LOAD = 5'h01;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_LOCK = 5'h09;
    localparam logic [4:0] CMD_REEN = 5'h11;
    // Lock and fuse values
    localparam logic [7:0] LOCK_RESET = 8'hff;
    localparam logic [7:0] LOCK_KEEP = 8'hc3;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    // Command windows in pclk cycles
    localparam logic [2:0] STORE_WINDOW = 3'h4;
    localparam logic [2:0] LPM_WINDOW = 3'h3;
    // Reset vectors and defaults of module parameters
    localparam logic [15:0] APP_RESET_ADDR = 16'h0000;
    localparam logic [15:0] BOOT_RESET_DEF = 16'h0c00;
    localparam int PAGE_WORDS_DEF = 32;
    localparam int HALT_FIRST_PAGE_DEF = 96;
    localparam int OP_CYCLES_DEF = 64;

    typedef struct packed {
        logic erase;
        logic write;
        logic [15:0] page;
    } fspc_flash_cmd_t;

    function automatic logic fspc_cmd_legal(input logic [4:0] c);
        return (c == CMD_LOAD) || (c == CMD_ERASE) || (c == CMD_WRITE) ||
               (c == CMD_LOCK) || (c == CMD_REEN);
    endfunction : fspc_cmd_legal

    function automatic logic fspc_addr_known(input logic [7:0] a);
        return (a == CTRL_OFS) || (a == PTR_OFS) || (a == DATA_OFS) ||
               (a == STORE_OFS) || (a == LOAD_OFS) || (a == STATUS_OFS);
    endfunction : fspc_addr_known
endpackage : fspc_pkg

/* File: design/fspc_page_buf.sv */
// Temporary page buffer: one word per page slot, any write order, bulk clear.
// Assumes the caller never clears and writes in the same cycle; clear wins if it does.
`timescale 1ns/1ns
module fspc_page_buf
    import fspc_pkg::*;
#(
    parameter int WORDS = PAGE_WORDS_DEF,
    parameter int DW = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic wr_en,
    input wire logic [$clog2(WORDS)-1:0] wr_idx,
    input wire logic [DW-1:0] wr_data,
    input wire logic [$clog2(WORDS)-1:0] rd_idx,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem [WORDS];
    logic [WORDS-1:0] valid_q;

    // A valid bit per word lets a clear act in one cycle without a reset on the array
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_q <= '0;
        end else if (clear) begin
            valid_q <= '0;
        end else if (wr_en) begin
            valid_q[wr_idx] <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '1;
        end else begin
            rd_data <= valid_q[rd_idx] ? mem[rd_idx] : '1;
        end
    end
endmodule : fspc_page_buf

/* File: verif/fspc_flash_model.sv */
// Flash array side: reads the page buffer out after a page-write pulse.
// Assumes one pclk domain and buffer read data one cycle after the index.
`timescale 1ns/1ns
module fspc_flash_model
    import fspc_pkg::*;
#(
    parameter int W = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input fspc_flash_cmd_t cmd,
    input wire logic [15:0] buf_data,
    output logic [$clog2(W)-1:0] idx
);
    localparam int IW = $clog2(W);
    logic [15:0] cap [W];
    logic act_q;
    logic pv_q;
    logic [$clog2(W)-1:0] pi_q;

    // Data lags the index by one cycle, so the slot is remembered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_q <= 1'b0;
            pv_q <= 1'b0;
            pi_q <= '0;
            idx <= '0;
        end else begin
            pv_q <= act_q;
            pi_q <= idx;
            if (pv_q) begin
                cap[pi_q] <= buf_data;
            end
            if (cmd.write) begin
                act_q <= 1'b1;
                idx <= '0;
            end else if (act_q) begin
                if (idx == IW'(W - 1)) begin
                    act_q <= 1'b0;
                end else begin
                    idx <= idx + 1'b1;
                end
            end
        end
    end
endmodule : fspc_flash_model

/* File: verif/fspc_ctrl_tb.sv */
// Self-checking bench for the self-programming controller.
// Assumes the APB slave answers with one wait state and a small OP_CYCLES.
`timescale 1ns/1ns
module fspc_ctrl_tb;
    import fspc_pkg::*;
    localparam int W = 4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
    logic [7:0] paddr, fuse_low, fuse_high, lock;
    logic [31:0] pwdata, prdata;
    logic boot_vector_fuse, global_irq_flag, eeprom_busy;
    logic flash_busy, cpu_halt, region_read_block, store_ready_irq;
    logic [1:0] bidx;
    logic [15:0] bdata, reset_vector;
    logic [15:0] wd [W];
    fspc_flash_cmd_t fcmd;
    logic [31:0] exp_q[$], msk_q[$];
    logic [4:0] bad [5] = '{5'h07, 5'h0d, 5'h02, 5'h1f, 5'h15};
    int error_cnt, compares;
    int ord [4] = '{3, 0, 2, 1};
    int z [3] = '{1, 0, 3};

    fspc_ctrl #(.PAGE_WORDS(W), .OP_CYCLES(8)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .boot_vector_fuse(boot_vector_fuse), .fuse_low(fuse_low), .fuse_high(fuse_high),
        .global_irq_flag(global_irq_flag), .eeprom_busy(eeprom_busy),
        .flash_buf_idx(bidx), .flash_buf_data(bdata), .flash_cmd(fcmd),
        .flash_busy(flash_busy), .cpu_halt(cpu_halt), .region_read_block(region_read_block),
        .store_ready_irq(store_ready_irq), .reset_vector(reset_vector));
    fspc_flash_model #(.W(W)) flash (.pclk(pclk), .presetn(presetn), .cmd(fcmd),
        .buf_data(bdata), .idx(bidx));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
        compares++;
        if (seen !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, e, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    // psel stays high between transfers so back-to-back setups never toggle it
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       input logic [31:0] e, input logic [31:0] m);
        if (!w) begin
            exp_q.push_back(e);
            msk_q.push_back(m);
        end
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        last_err = pslverr;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, 32'h0, 32'h0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(a, 1'b0, 32'h0, e, m);
    endtask : rd

    task automatic idle(input int n);
        psel <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask : idle

    task automatic cmd(input logic [4:0] c);
        wr(CTRL_OFS, {27'h0, c});
        wr(STORE_OFS, 32'h0);
    endtask : cmd

    task automatic op_wait;
        idle(1);
        while (flash_busy !== 1'b0) @(posedge pclk);
    endtask : op_wait

    always @(posedge pclk) begin : mon
        logic [31:0] e, m;
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            check("prdata", prdata & m, e);
        end
    end

    initial begin
        #(100 * 20000);
        check("watchdog", 0, 1);
        tally_and_finish();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {presetn, boot_vector_fuse, global_irq_flag, eeprom_busy} = '0;
        error_cnt = 0;
        compares = 0;
        void'($urandom(57187));
        fuse_low = $urandom;
        fuse_high = $urandom;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        check("reset_vector", reset_vector, BOOT_RESET_DEF);
        rd(CTRL_OFS, 32'h0, 32'hff);
        rd(8'h20, 32'h0, 32'h0);
        check("pslverr", last_err, 1);
        foreach (bad[i]) begin
            wr(CTRL_OFS, {27'h0, bad[i]});
            rd(CTRL_OFS, 32'h0, 32'h1f);
        end
        $display("test reset and illegal patterns done");
        // Readable page 5, erased before it is written
        wr(PTR_OFS, 32'h28);
        cmd(CMD_ERASE);
        idle(1);
        check("region_block", region_read_block, 1);
        check("cpu_halt", cpu_halt, 0);
        check("flash_busy", flash_busy, 1);
        rd(CTRL_OFS, 32'h43, 32'hff);
        op_wait();
        rd(CTRL_OFS, 32'h40, 32'hff);
        foreach (ord[i]) begin
            wd[ord[i]] = $urandom;
            wr(PTR_OFS, 32'h28 | (ord[i] << 1) | 1);
            wr(DATA_OFS, {16'h0, wd[ord[i]]});
            cmd(CMD_LOAD);
        end
        idle(1);
        check("region_block", region_read_block, 0);
        wr(PTR_OFS, 32'h28);
        cmd(CMD_WRITE);
        op_wait();
        for (int i = 0; i < W; i++) check("page_word", flash.cap[i], wd[i]);
        check("region_block", region_read_block, 1);
        cmd(CMD_REEN);
        idle(1);
        check("region_block", region_read_block, 0);
        $display("test readable page done");
        // Halting page 96, pointer moved while the erase runs
        wr(PTR_OFS, 32'h300);
        cmd(CMD_ERASE);
        wr(PTR_OFS, 32'h0);
        check("cpu_halt", cpu_halt, 1);
        check("page", fcmd.page, 16'h0060);
        op_wait();
        check("cpu_halt", cpu_halt, 0);
        wr(PTR_OFS, 32'h30);
        wr(DATA_OFS, $urandom);
        cmd(CMD_LOAD);
        cmd(CMD_REEN);
        cmd(CMD_WRITE);
        op_wait();
        for (int i = 0; i < W; i++) check("cleared", flash.cap[i], 16'hffff);
        $display("test halting page and buffer abort done");
        lock = 8'hff & ($urandom | 8'hc3);
        wr(PTR_OFS, $urandom & 32'hffff);
        wr(DATA_OFS, {24'h0, lock});
        cmd(CMD_LOCK);
        rd(STATUS_OFS, lock, 32'hff);
        foreach (z[i]) begin
            wr(PTR_OFS, z[i]);
            wr(CTRL_OFS, CMD_LOCK);
            rd(LOAD_OFS, i == 0 ? lock : i == 1 ? fuse_low : fuse_high, 32'hff);
        end
        rd(LOAD_OFS, 32'hff, 32'hff);
        wr(CTRL_OFS, CMD_LOCK);
        idle(4);
        rd(CTRL_OFS, 32'h0, 32'h1f);
        wr(DATA_OFS, 32'h0);
        wr(CTRL_OFS, CMD_LOCK);
        idle(2);
        wr(STORE_OFS, 32'h0);
        rd(STATUS_OFS, lock, 32'hff);
        eeprom_busy <= 1'b1;
        wr(CTRL_OFS, CMD_LOCK);
        rd(CTRL_OFS, 32'h0, 32'h1f);
        wr(PTR_OFS, 32'h1);
        rd(LOAD_OFS, 32'hff, 32'hff);
        eeprom_busy <= 1'b0;
        $display("test lock and fuse access done");
        global_irq_flag <= 1'b1;
        wr(CTRL_OFS, 32'h80);
        idle(1);
        check("irq", store_ready_irq, 1);
        wr(CTRL_OFS, 32'h81);
        idle(1);
        check("irq", store_ready_irq, 0);
        idle(4);
        check("irq", store_ready_irq, 1);
        global_irq_flag <= 1'b0;
        idle(1);
        check("irq", store_ready_irq, 0);
        presetn <= 1'b0;
        boot_vector_fuse <= 1'b1;
        idle(2);
        presetn <= 1'b1;
        idle(2);
        check("reset_vector", reset_vector, APP_RESET_ADDR);
        rd(CTRL_OFS, 32'h0, 32'hff);
        idle(1);
        $display("test interrupt and second reset done");
        tally_and_finish();
    end
endmodule : fspc_ctrl_tb
